// *** logic/pucs_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - configuration is captured once after each reset; the program cannot change it.
// - configuration bytes are programmed through the same command port as code.
// - reading external-data address FD00h returns configuration byte one, read-only.
// - reset-pin-disable set makes the shared pin a plain input, no reset.
// - both security bits unprogrammed: verify and programming allowed, except programming security bit two.
// - only security bit one programmed: programming refused, verify still allowed.
// - only security bit one programmed: security bit two may still be programmed.
// - both security bits programmed: verify and programming are all refused.
module pucs_top
  import pucs_pkg::*;
#(
  parameter int CODE_AW = 12
) (
  input  wire logic               I_REF_CLK,
  input  wire logic               I_NRST,
  input  wire logic               I_XDATA_RD,
  input  wire logic [15:0]        I_XDATA_ADDR,
  input  wire logic               I_PROG_REQ,
  input  wire logic [2:0]         I_PROG_CMD,
  input  wire logic [CODE_AW-1:0] I_PROG_ADDR,
  input  wire logic [7:0]         I_PROG_DATA,
  input  wire logic               I_SHARED_RESET_INPUT_PIN,
  output logic                    O_XDATA_VALID,
  output logic      [7:0]         O_XDATA_RDATA,
  output logic                    O_PROG_DONE,
  output logic                    O_PROG_REFUSED,
  output logic                    O_PMEM_WR,
  output logic                    O_PMEM_RD,
  output logic      [CODE_AW-1:0] O_PMEM_ADDR,
  output logic      [7:0]         O_PMEM_WDATA,
  output logic                    O_CONFIG_READY,
  output logic                    O_PIN_RESET_REQ,
  output logic                    O_SHARED_PIN_IN,
  output logic                    O_PORT_RESET_LEVEL,
  output logic      [2:0]         O_OSC_SELECT,
  output logic                    O_OSC_RESERVED,
  output logic      [1:0]         O_SECURITY
);
  pucs_state_t     state_q;
  logic [7:0]      cfg1_q;
  logic [1:0]      sec_q;
  logic [7:0]      nvm_rdata;
  logic [1:0]      nvm_raddr;
  logic            nvm_we;
  logic [1:0]      nvm_waddr;
  logic [7:0]      nvm_wdata;
  logic            ready;
  logic            cmd_ok;
  logic            accept;
  logic            pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  logic [2:0]      osc_field;

  assign ready     = (state_q == PUCS_ST_RUN);
  assign cmd_ok    = pucs_cmd_allowed(I_PROG_CMD, sec_q[PUCS_SEC_ONE_BIT],
                                      sec_q[PUCS_SEC_TWO_BIT]);
  assign accept    = I_PROG_REQ && ready && cmd_ok;
  assign osc_field = cfg1_q[PUCS_OSC_LSB +: PUCS_OSC_W];

  // power-up load: read byte one, then the security cell
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q <= PUCS_ST_START;
    end else begin
      unique case (state_q)
        PUCS_ST_START: state_q <= PUCS_ST_RDCFG;
        PUCS_ST_RDCFG: state_q <= PUCS_ST_RDSEC;
        PUCS_ST_RDSEC: state_q <= PUCS_ST_RUN;
        PUCS_ST_RUN:   state_q <= PUCS_ST_RUN;
      endcase
    end
  end

  always_comb begin
    nvm_raddr = PUCS_NVM_CFG1;
    if (state_q == PUCS_ST_RDCFG) begin
      nvm_raddr = PUCS_NVM_SEC;
    end
  end

  // configuration shadow is written only during the load
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg1_q <= PUCS_ERASED_BYTE;
    end else if (state_q == PUCS_ST_RDCFG) begin
      cfg1_q <= nvm_rdata;
    end
  end

  // security state is live: a programmed bit takes effect at once
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sec_q <= PUCS_SEC_ERASED;
    end else if (state_q == PUCS_ST_RDSEC) begin
      sec_q <= {nvm_rdata[PUCS_SEC_TWO_BIT], nvm_rdata[PUCS_SEC_ONE_BIT]};
    end else if (accept && I_PROG_CMD == PUCS_CMD_PROG_SEC_ONE) begin
      sec_q[PUCS_SEC_ONE_BIT] <= 1'b0;
    end else if (accept && I_PROG_CMD == PUCS_CMD_PROG_SEC_TWO) begin
      sec_q[PUCS_SEC_TWO_BIT] <= 1'b0;
    end
  end

  // configuration and security cells use the code programming path
  always_comb begin
    nvm_we    = 1'b0;
    nvm_waddr = PUCS_NVM_CFG1;
    nvm_wdata = I_PROG_DATA;
    if (accept) begin
      unique case (I_PROG_CMD)
        PUCS_CMD_PROG_CFG1: begin
          nvm_we = 1'b1;
        end
        PUCS_CMD_PROG_CFG2: begin
          nvm_we    = 1'b1;
          nvm_waddr = PUCS_NVM_CFG2;
        end
        PUCS_CMD_PROG_SEC_ONE: begin
          nvm_we    = 1'b1;
          nvm_waddr = PUCS_NVM_SEC;
          nvm_wdata = PUCS_SEC_ONE_PROG_VAL;
        end
        PUCS_CMD_PROG_SEC_TWO: begin
          nvm_we    = 1'b1;
          nvm_waddr = PUCS_NVM_SEC;
          nvm_wdata = PUCS_SEC_TWO_PROG_VAL;
        end
        default: begin
          nvm_we = 1'b0;
        end
      endcase
    end
  end

  pucs_nvm #(
    .AW    (PUCS_NVM_AW),
    .DEPTH (PUCS_NVM_DEPTH)
  ) u_nvm (
    .i_clk   (I_REF_CLK),
    .i_we    (nvm_we),
    .i_waddr (nvm_waddr),
    .i_wdata (nvm_wdata),
    .i_raddr (nvm_raddr),
    .o_rdata (nvm_rdata)
  );

  // command answer: one pulse, done or refused, the cycle after the request
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PROG_DONE    <= 1'b0;
      O_PROG_REFUSED <= 1'b0;
      O_PMEM_WR      <= 1'b0;
      O_PMEM_RD      <= 1'b0;
    end else begin
      O_PROG_DONE    <= accept;
      O_PROG_REFUSED <= I_PROG_REQ && !accept;
      O_PMEM_WR      <= accept && (I_PROG_CMD == PUCS_CMD_PROG_CODE);
      O_PMEM_RD      <= accept && (I_PROG_CMD == PUCS_CMD_VERIFY);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PMEM_ADDR  <= '0;
      O_PMEM_WDATA <= PUCS_ZERO_BYTE;
    end else if (accept) begin
      O_PMEM_ADDR  <= I_PROG_ADDR;
      O_PMEM_WDATA <= I_PROG_DATA;
    end
  end

  // read-only byte in external-data space
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_XDATA_VALID <= 1'b0;
      O_XDATA_RDATA <= PUCS_ZERO_BYTE;
    end else begin
      O_XDATA_VALID <= I_XDATA_RD && ready && (I_XDATA_ADDR == PUCS_CFG_ONE_XADDR);
      O_XDATA_RDATA <= PUCS_ZERO_BYTE;
      if (I_XDATA_RD && ready && (I_XDATA_ADDR == PUCS_CFG_ONE_XADDR)) begin
        O_XDATA_RDATA <= cfg1_q;
      end
    end
  end

  // shared pin: three stages, a change counts when the last two agree
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      pin_q    <= 1'b0;
    end else begin
      pin_s1_q <= I_SHARED_RESET_INPUT_PIN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q) begin
        pin_q <= pin_s3_q;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PIN_RESET_REQ <= 1'b0;
      O_SHARED_PIN_IN <= 1'b0;
    end else begin
      O_PIN_RESET_REQ <= ready && pin_q && !cfg1_q[PUCS_PIN_DIS_BIT];
      O_SHARED_PIN_IN <= ready && pin_q && cfg1_q[PUCS_PIN_DIS_BIT];
    end
  end

  // configuration outputs
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CONFIG_READY     <= 1'b0;
      O_PORT_RESET_LEVEL <= 1'b1;
      O_OSC_SELECT       <= PUCS_OSC_EXT_CLK;
      O_OSC_RESERVED     <= 1'b0;
      O_SECURITY         <= PUCS_SEC_ERASED;
    end else begin
      O_CONFIG_READY     <= ready;
      O_PORT_RESET_LEVEL <= cfg1_q[PUCS_PORT_HI_BIT];
      O_OSC_SELECT       <= osc_field;
      O_OSC_RESERVED     <= (osc_field > PUCS_OSC_INT_RC) && (osc_field != PUCS_OSC_EXT_CLK);
      O_SECURITY         <= sec_q;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_req(logic [2:0] c);
    I_PROG_REQ && ready && (I_PROG_CMD == c);
  endsequence

  sequence s_refused;
    O_PROG_REFUSED && !O_PROG_DONE && !O_PMEM_WR && !O_PMEM_RD;
  endsequence

  cfg_frozen_a: assert property (ready |=> $stable(cfg1_q))
    else $error("configuration changed after load");
  cfg_load_a: assert property ((state_q == PUCS_ST_START) |-> ##3 ready)
    else $error("configuration load did not finish in three cycles");
  xdata_read_a: assert property (
    (I_XDATA_RD && ready && I_XDATA_ADDR == PUCS_CFG_ONE_XADDR)
    |=> O_XDATA_VALID && (O_XDATA_RDATA == cfg1_q))
    else $error("configuration byte not returned");
  pin_disable_a: assert property ((ready && cfg1_q[PUCS_PIN_DIS_BIT]) |=> !O_PIN_RESET_REQ)
    else $error("reset taken from disabled pin");
  port_level_a: assert property (
    ready |=> O_PORT_RESET_LEVEL == $past(cfg1_q[PUCS_PORT_HI_BIT]))
    else $error("port reset level mismatch");
  osc_select_a: assert property (ready |=> O_OSC_SELECT == $past(osc_field))
    else $error("oscillator select mismatch");
  open_verify_a: assert property (
    (s_req(PUCS_CMD_VERIFY) and (sec_q == 2'h3)) |=> O_PROG_DONE && O_PMEM_RD)
    else $error("verify refused on open part");
  lock_prog_a: assert property (
    (s_req(PUCS_CMD_PROG_CODE) and !sec_q[PUCS_SEC_ONE_BIT]) |=> s_refused)
    else $error("code programmed while locked");
  sec_two_ok_a: assert property (
    (s_req(PUCS_CMD_PROG_SEC_TWO) and (sec_q == 2'h2)) |=> O_PROG_DONE ##1 (sec_q == 2'h0))
    else $error("second security bit not accepted");
  verify_lock_a: assert property (
    (s_req(PUCS_CMD_VERIFY) and (sec_q == 2'h0)) |=> s_refused)
    else $error("verify allowed with both bits set");
  sec_two_order_a: assert property (
    (s_req(PUCS_CMD_PROG_SEC_TWO) and sec_q[PUCS_SEC_ONE_BIT])
    |=> s_refused ##1 sec_q[PUCS_SEC_TWO_BIT])
    else $error("second security bit taken out of order");
endmodule

// *** logic/pucs_pkg.sv ***
package pucs_pkg;
  // external-data address of the first configuration byte
  localparam logic [15:0] PUCS_CFG_ONE_XADDR = 16'hFD00;
  localparam logic [7:0]  PUCS_ERASED_BYTE = 8'hFF;
  localparam logic [7:0]  PUCS_ZERO_BYTE   = 8'h00;

  // field positions in user_config_byte_one
  localparam int PUCS_WDOG_FUSE_BIT = 7;
  localparam int PUCS_PIN_DIS_BIT   = 6;
  localparam int PUCS_PORT_HI_BIT   = 5;
  localparam int PUCS_BROWNOUT_BIT  = 4;
  localparam int PUCS_CLK_RATE_BIT  = 3;
  localparam int PUCS_OSC_LSB  = 0;
  localparam int PUCS_OSC_W    = 3;

  // non-volatile cell indices and security bit positions
  localparam int         PUCS_NVM_AW       = 2;
  localparam int         PUCS_NVM_DEPTH    = 3;
  localparam logic [1:0] PUCS_NVM_CFG1     = 2'h0;
  localparam logic [1:0] PUCS_NVM_CFG2     = 2'h1;
  localparam logic [1:0] PUCS_NVM_SEC      = 2'h2;
  localparam int         PUCS_SEC_ONE_BIT      = 0;
  localparam int         PUCS_SEC_TWO_BIT      = 1;
  localparam logic [7:0] PUCS_SEC_ONE_PROG_VAL = 8'hFE;
  localparam logic [7:0] PUCS_SEC_TWO_PROG_VAL = 8'hFD;
  localparam logic [1:0] PUCS_SEC_ERASED       = 2'h3;

  typedef enum logic [2:0] {
    PUCS_OSC_HF_XTAL = 3'h0,
    PUCS_OSC_MF_XTAL = 3'h1,
    PUCS_OSC_LF_XTAL = 3'h2,
    PUCS_OSC_INT_RC  = 3'h3,
    PUCS_OSC_EXT_CLK = 3'h7
  } pucs_osc_t;

  typedef enum logic [2:0] {
    PUCS_CMD_PROG_CODE = 3'h0,
    PUCS_CMD_VERIFY    = 3'h1,
    PUCS_CMD_PROG_CFG1 = 3'h2,
    PUCS_CMD_PROG_CFG2 = 3'h3,
    PUCS_CMD_PROG_SEC_ONE = 3'h4,
    PUCS_CMD_PROG_SEC_TWO = 3'h5
  } pucs_cmd_t;

  typedef enum logic [1:0] {
    PUCS_ST_START = 2'b00,
    PUCS_ST_RDCFG = 2'b01,
    PUCS_ST_RDSEC = 2'b11,
    PUCS_ST_RUN   = 2'b10
  } pucs_state_t;

  // protection decision for one programming command
  function automatic logic pucs_cmd_allowed(input logic [2:0] cmd,
                                            input logic       sec_one,
                                            input logic       sec_two);
    logic ok;
    ok = 1'b0;
    if (sec_one && sec_two) begin
      ok = (cmd <= PUCS_CMD_PROG_SEC_ONE);
    end else if (!sec_one && sec_two) begin
      ok = (cmd == PUCS_CMD_VERIFY) || (cmd == PUCS_CMD_PROG_SEC_TWO);
    end
    return ok;
  endfunction
endpackage

// *** logic/pucs_nvm.sv ***
`timescale 1ns/1ps
// non-volatile cell array; programming can only clear bits
module pucs_nvm
  import pucs_pkg::*;
#(
  parameter int AW    = PUCS_NVM_AW,
  parameter int DEPTH = PUCS_NVM_DEPTH
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  // an unprogrammed part holds the erased value in every cell; reset never clears it
  logic [7:0] cell_q [DEPTH] = '{default: PUCS_ERASED_BYTE};

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      cell_q[i_waddr] <= cell_q[i_waddr] & i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata <= cell_q[i_raddr];
  end
endmodule

// *** tb/pucs_prog_model.sv ***
`timescale 1ns/1ps
// external programmer: one command per call, config bytes on the code path
module pucs_prog_model
  import pucs_pkg::*;
#(
  parameter int CODE_AW = 12
) (
  input  wire logic               i_clk,
  input  wire logic [1:0]         i_security,
  input  wire logic               i_allow_bad,
  output logic                    o_req,
  output logic      [2:0]         o_cmd,
  output logic      [CODE_AW-1:0] o_addr,
  output logic      [7:0]         o_data
);
  initial begin
    o_req  = 1'b0;
    o_cmd  = 3'h0;
    o_addr = '0;
    o_data = 8'h00;
  end

  task automatic send(input logic [2:0] cmd, input logic [CODE_AW-1:0] a,
                      input logic [7:0] d, output logic sent);
    sent = !(cmd == PUCS_CMD_PROG_SEC_TWO && i_security[PUCS_SEC_ONE_BIT] && !i_allow_bad);
    @(posedge i_clk);
    if (sent) begin
      o_req  <= 1'b1;
      o_cmd  <= cmd;
      o_addr <= a;
      o_data <= d;
    end
    @(posedge i_clk);
    // released lines must not keep their last value
    o_req  <= 1'b0;
    o_cmd  <= ~cmd;
    o_addr <= ~a;
    o_data <= ~d;
  endtask
endmodule

// *** tb/power_up_config_and_code_security_tb_top.sv ***
`timescale 1ns/1ps
module power_up_config_and_code_security_tb_top
  import pucs_pkg::*;
;
  typedef struct packed {
    logic [7:0] data;
    logic       lvl;
    logic [2:0] osc;
    logic       rsv;
  } pucs_row_t;

  logic        I_REF_CLK, I_NRST, I_XDATA_RD, I_PROG_REQ, I_SHARED_RESET_INPUT_PIN;
  logic [15:0] I_XDATA_ADDR;
  logic [2:0]  I_PROG_CMD, O_OSC_SELECT;
  logic [11:0] I_PROG_ADDR, O_PMEM_ADDR, last_a;
  logic [7:0]  I_PROG_DATA, O_XDATA_RDATA, O_PMEM_WDATA;
  logic        O_XDATA_VALID, O_PROG_DONE, O_PROG_REFUSED, O_PMEM_WR, O_PMEM_RD;
  logic        O_CONFIG_READY, O_PIN_RESET_REQ, O_SHARED_PIN_IN, O_PORT_RESET_LEVEL;
  logic        O_OSC_RESERVED, bad, sent;
  logic [1:0]  O_SECURITY;
  logic [2:0]  prev_osc;
  int          n_errors, comparisons, cycles;
  pucs_row_t   rows [4] = '{'{8'hFF, 1'b1, 3'h7, 1'b0}, '{8'hBD, 1'b1, 3'h5, 1'b1},
                            '{8'h99, 1'b0, 3'h1, 1'b0}, '{8'h98, 1'b0, 3'h0, 1'b0}};

  pucs_top u_dut (
    .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_XDATA_RD(I_XDATA_RD),
    .I_XDATA_ADDR(I_XDATA_ADDR), .I_PROG_REQ(I_PROG_REQ), .I_PROG_CMD(I_PROG_CMD),
    .I_PROG_ADDR(I_PROG_ADDR), .I_PROG_DATA(I_PROG_DATA),
    .I_SHARED_RESET_INPUT_PIN(I_SHARED_RESET_INPUT_PIN), .O_XDATA_VALID(O_XDATA_VALID),
    .O_XDATA_RDATA(O_XDATA_RDATA), .O_PROG_DONE(O_PROG_DONE),
    .O_PROG_REFUSED(O_PROG_REFUSED), .O_PMEM_WR(O_PMEM_WR), .O_PMEM_RD(O_PMEM_RD),
    .O_PMEM_ADDR(O_PMEM_ADDR), .O_PMEM_WDATA(O_PMEM_WDATA),
    .O_CONFIG_READY(O_CONFIG_READY), .O_PIN_RESET_REQ(O_PIN_RESET_REQ),
    .O_SHARED_PIN_IN(O_SHARED_PIN_IN), .O_PORT_RESET_LEVEL(O_PORT_RESET_LEVEL),
    .O_OSC_SELECT(O_OSC_SELECT), .O_OSC_RESERVED(O_OSC_RESERVED), .O_SECURITY(O_SECURITY)
  );

  pucs_prog_model u_prog (
    .i_clk(I_REF_CLK), .i_security(O_SECURITY), .i_allow_bad(bad),
    .o_req(I_PROG_REQ), .o_cmd(I_PROG_CMD), .o_addr(I_PROG_ADDR), .o_data(I_PROG_DATA)
  );

  initial begin
    I_REF_CLK = 1'b0;
    forever #2 I_REF_CLK = ~I_REF_CLK;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  // reset for two edges, optionally probe a request before the load is done
  task automatic rst(input logic early);
    int k;
    @(posedge I_REF_CLK) I_NRST <= 1'b0;
    @(posedge I_REF_CLK);
    #1;
    chk(O_PORT_RESET_LEVEL, 1'b1, "rst lvl");
    chk(O_OSC_SELECT, PUCS_OSC_EXT_CLK, "rst osc");
    chk(O_CONFIG_READY, 1'b0, "rst rdy");
    @(posedge I_REF_CLK) I_NRST <= 1'b1;
    last_a = '0;
    if (early) op(PUCS_CMD_VERIFY, 12'h0, 8'h0, 1'b0);
    k = 0;
    while (O_CONFIG_READY !== 1'b1 && k < 10) begin
      @(posedge I_REF_CLK);
      #1;
      k++;
    end
    chk(O_CONFIG_READY, 1'b1, "ready");
  endtask

  task automatic op(input logic [2:0] c, input logic [11:0] a, input logic [7:0] d,
                    input logic ok);
    u_prog.send(c, a, d, sent);
    #1;
    if (ok) last_a = a;
    chk(O_PROG_DONE, ok, "done");
    chk(O_PROG_REFUSED, !ok, "refused");
    chk(O_PMEM_WR, ok && c == PUCS_CMD_PROG_CODE, "pmem wr");
    chk(O_PMEM_RD, ok && c == PUCS_CMD_VERIFY, "pmem rd");
    chk(O_PMEM_ADDR, last_a, "pmem addr");
    if (ok && c == PUCS_CMD_PROG_CODE) chk(O_PMEM_WDATA, d, "pmem data");
  endtask

  task automatic xrd(input logic [15:0] a, input logic v, input logic [7:0] d);
    @(posedge I_REF_CLK) begin
      I_XDATA_RD   <= 1'b1;
      I_XDATA_ADDR <= a;
    end
    @(posedge I_REF_CLK) I_XDATA_RD <= 1'b0;
    #1;
    chk(O_XDATA_VALID, v, "xvalid");
    chk(O_XDATA_RDATA, v ? d : 8'h00, "xdata");
  endtask

  task automatic pin(input logic reset_pin_disable);
    @(posedge I_REF_CLK) I_SHARED_RESET_INPUT_PIN <= 1'b1;
    repeat (6) @(posedge I_REF_CLK);
    #1;
    chk(O_PIN_RESET_REQ, !reset_pin_disable, "pin rst");
    chk(O_SHARED_PIN_IN, reset_pin_disable, "pin in");
    @(posedge I_REF_CLK) I_SHARED_RESET_INPUT_PIN <= 1'b0;
    repeat (6) @(posedge I_REF_CLK);
    #1;
    chk({O_PIN_RESET_REQ, O_SHARED_PIN_IN}, 2'b00, "pin low");
  endtask

  always @(posedge I_REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    I_NRST = 1'b0;
    I_XDATA_RD = 1'b0;
    I_XDATA_ADDR = 16'h0000;
    I_SHARED_RESET_INPUT_PIN = 1'b0;
    bad = 1'b0;
    prev_osc = PUCS_OSC_EXT_CLK;
    rst(1'b1);
    foreach (rows[i]) begin
      op(PUCS_CMD_PROG_CFG1, 12'h0, rows[i].data, 1'b1);
      chk(O_OSC_SELECT, prev_osc, "osc held");
      rst(1'b0);
      xrd(PUCS_CFG_ONE_XADDR, 1'b1, rows[i].data);
      chk(O_PORT_RESET_LEVEL, rows[i].lvl, "lvl");
      chk(O_OSC_SELECT, rows[i].osc, "osc");
      chk(O_OSC_RESERVED, rows[i].rsv, "osc rsv");
      pin(rows[i].data[PUCS_PIN_DIS_BIT]);
      prev_osc = rows[i].osc;
    end
    xrd(16'hFD01, 1'b0, 8'h00);
    chk(O_SECURITY, 2'b11, "sec");
    op(PUCS_CMD_VERIFY, 12'h123, 8'h00, 1'b1);
    op(PUCS_CMD_PROG_CODE, 12'hABC, 8'h5A, 1'b1);
    op(PUCS_CMD_PROG_CFG2, 12'h0, 8'hFF, 1'b1);
    op(3'h6, 12'h0, 8'h00, 1'b0);
    u_prog.send(PUCS_CMD_PROG_SEC_TWO, 12'h0, 8'h0, sent);
    chk(sent, 1'b0, "bit two held back");
    bad = 1'b1;
    op(PUCS_CMD_PROG_SEC_TWO, 12'h0, 8'h0, 1'b0);
    bad = 1'b0;
    op(PUCS_CMD_PROG_SEC_ONE, 12'h010, 8'h0, 1'b1);
    @(posedge I_REF_CLK);
    #1;
    chk(O_SECURITY, 2'b10, "sec one");
    op(PUCS_CMD_PROG_CODE, 12'h222, 8'h00, 1'b0);
    op(PUCS_CMD_PROG_CFG1, 12'h0, 8'h00, 1'b0);
    op(PUCS_CMD_PROG_CFG2, 12'h0, 8'h00, 1'b0);
    op(PUCS_CMD_VERIFY, 12'h333, 8'h00, 1'b1);
    op(PUCS_CMD_PROG_SEC_TWO, 12'h020, 8'h0, 1'b1);
    @(posedge I_REF_CLK);
    #1;
    chk(O_SECURITY, 2'b00, "sec both");
    op(PUCS_CMD_VERIFY, 12'h444, 8'h00, 1'b0);
    op(PUCS_CMD_PROG_CODE, 12'h555, 8'h00, 1'b0);
    rst(1'b0);
    chk(O_SECURITY, 2'b00, "sec kept");
    op(PUCS_CMD_VERIFY, 12'h666, 8'h00, 1'b0);
    tally_and_finish();
  end
endmodule
